// ---- bench/branch_inc_or_shift_exec_tb.sv ----
// self-checking bench for the six-operation execution block
// assumes the register port map and op timing of the design
`timescale 1ns/1ps
module branch_inc_or_shift_exec_tb;
   import exec_pkg::*;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic issue = 1'b0;
   op_t op = no_operation;
   logic [FADDR_W-1:0] file_addr = 7'h00;
   logic dest_sel = 1'b0;
   logic [IMM_W-1:0] literal = 11'h000;
   logic [LATCH_W-1:0] upper_pc_latch = 7'h00;
   logic [BUS_ADDR_W-1:0] bus_addr = 8'h00;
   logic [DATA_W-1:0] bus_wdata = 8'h00;
   logic bus_wr = 1'b0;
   logic bus_rd = 1'b0;
   logic [DATA_W-1:0] bus_rdata_reg;
   logic busy_reg;
   logic done_reg;
   logic [DATA_W-1:0] acc_reg;
   logic carry_reg;
   logic zero_reg;
   logic [PC_W-1:0] pc_reg;
   int bad_count = 0;
   int samples_checked = 0;
   logic [7:0] exp_q[$];
   string name_q[$];
   logic rd_q = 1'b0;
   logic [7:0] acc_m = 8'h00;
   logic z_m = 1'b0;
   logic c_m = 1'b0;
   logic [14:0] pc_m = 15'h0000;
   logic [7:0] file_m [128];
   logic [15:0] seed = 16'h9a10;

   always #50 clk = ~clk;

   branch_inc_or_shift_exec branch_inc_or_shift_exec_inst (.clk(clk), .reset_n(reset_n),
      .issue(issue), .op(op), .file_addr(file_addr), .dest_sel(dest_sel), .literal(literal),
      .upper_pc_latch(upper_pc_latch), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_reg(bus_rdata_reg), .busy_reg(busy_reg),
      .done_reg(done_reg), .acc_reg(acc_reg), .carry_reg(carry_reg), .zero_reg(zero_reg),
      .pc_reg(pc_reg));

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      samples_checked++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         bad_count++;
      end
   endtask

   task automatic summarize();
      repeat (3) @(posedge clk);
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // read data first stand in the cycle after the strobe, so they are taken there
   always @(posedge clk) rd_q <= bus_rd;
   always @(negedge clk) begin
      if (rd_q && exp_q.size() > 0)
         check(name_q.pop_front(), exp_q.pop_front(), bus_rdata_reg);
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic bus_write(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr <= a;
      bus_wdata <= d;
      bus_wr <= 1'b1;
      @(posedge clk);
      bus_wr <= 1'b0;
   endtask

   task automatic bus_read(input logic [7:0] a, input logic [7:0] e, input string n);
      exp_q.push_back(e);
      name_q.push_back(n);
      @(posedge clk);
      bus_addr <= a;
      bus_rd <= 1'b1;
      @(posedge clk);
      bus_rd <= 1'b0;
   endtask

   task automatic check_state(input logic [6:0] f);
      bus_read(ACC_OFFSET, acc_m, "acc");
      bus_read(STATUS_OFFSET, {5'h00, z_m, 1'b0, c_m}, "status");
      bus_read(PC_LO_OFFSET, pc_m[7:0], "pc_lo");
      bus_read(PC_HI_OFFSET, {1'b0, pc_m[14:8]}, "pc_hi");
      bus_read({1'b0, f}, file_m[f], "file");
   endtask

   task automatic run_op(input op_t o, input logic [6:0] f, input logic d,
                         input logic [10:0] lit, input logic [6:0] lat);
      logic [7:0] fv;
      logic [7:0] r;
      logic [14:0] step;
      int cyc;
      int n;
      fv = file_m[f];
      r = 8'h00;
      step = PC_STEP;
      cyc = 1;
      n = 0;
      case (o)
         jump_absolute: cyc = 2;
         increment_skip_zero: begin
            r = fv + 8'h01;
            if (r == 8'h00) begin
               step = PC_SKIP_STEP;
               cyc = 2;
            end
         end
         increment_file: r = fv + 8'h01;
         or_literal_acc: r = acc_m | lit[7:0];
         or_acc_file: r = acc_m | fv;
         shift_left_file: begin
            c_m = fv[7];
            r = {fv[6:0], 1'b0};
         end
         default: ;
      endcase
      if (o == jump_absolute)
         pc_m = {lat[6:3], lit};
      else
         pc_m = pc_m + step;
      if (o inside {increment_skip_zero, increment_file, or_acc_file, shift_left_file}) begin
         if (d)
            file_m[f] = r;
         else
            acc_m = r;
      end
      if (o == or_literal_acc)
         acc_m = r;
      if (o inside {increment_file, or_literal_acc, or_acc_file, shift_left_file})
         z_m = (r == 8'h00);
      @(posedge clk);
      issue <= 1'b1;
      op <= o;
      file_addr <= f;
      dest_sel <= d;
      literal <= lit;
      upper_pc_latch <= lat;
      @(posedge clk);
      issue <= 1'b0;
      // look only at settled values, never in the step of the edge that takes the op
      do begin
         @(negedge clk);
         n++;
         if (n == 1)
            check("busy", {7'h00, cyc == 2}, {7'h00, busy_reg});
      end while (n < 8 && done_reg !== 1'b1);
      if (done_reg !== 1'b1) begin
         check("done_wait", 8'h01, 8'h00);
         summarize();
      end else begin
         check("cycles", cyc[7:0], n[7:0]);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [7:0] v;
      logic [15:0] s2;
      for (int k = 0; k < 128; k++)
         file_m[k] = FILE_RESET;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      check_state(7'h00);
      bus_write(8'h90, 8'h5a);
      bus_read(8'h90, 8'h00, "unmapped");
      // status and pc are read-only: writes there must leave them as they were
      bus_write(STATUS_OFFSET, 8'hff);
      bus_write(PC_LO_OFFSET, 8'hff);
      check_state(7'h00);
      $display("test reset and register map done");
      // ops in turn, with all-ones and all-zero operands to reach carry, zero and skip
      for (int i = 0; i < 42; i++) begin
         seed = lfsr_next(seed);
         s2 = lfsr_next(seed);
         v = (i % 3 == 0) ? 8'hff : ((i % 3 == 1) ? 8'h00 : seed[15:8]);
         bus_write({1'b0, seed[6:0]}, v);
         file_m[seed[6:0]] = v;
         acc_m = (i % 2 == 1) ? 8'h00 : s2[7:0] ^ seed[7:0];
         bus_write(ACC_OFFSET, acc_m);
         run_op(op_t'(i % 7), seed[6:0], s2[0], seed[11:1], seed[15:9]);
         check_state(seed[6:0]);
      end
      $display("test op sweep done");
      // back-to-back single-cycle ops with no gap between the takes
      acc_m = 8'h00;
      bus_write(ACC_OFFSET, 8'h00);
      @(posedge clk);
      issue <= 1'b1;
      op <= or_literal_acc;
      literal <= 11'h701;
      @(posedge clk);
      literal <= 11'h080;
      @(posedge clk);
      issue <= 1'b0;
      acc_m = 8'h81;
      z_m = 1'b0;
      pc_m = pc_m + 15'h0002;
      check_state(7'h00);
      $display("test back to back done");
      summarize();
   end
endmodule

// ---- core/branch_inc_or_shift_exec.sv ----
// execution of six 8-bit core operations with accumulator, flags and pc
// assumes op fields are already decoded by a fetch stage outside
//
// What this block does
// - an absolute jump loads its 11-bit immediate into pc bits 10:0.
// - the same jump fills pc bits 14:11 from upper latch bits 6:3.
// - the jump takes two cycles and leaves carry and zero untouched.
// - with the destination bit 0 a result goes to the accumulator, with 1 back to the file.
// - increment-skip writes f+1 without touching flags and on zero burns a second nop cycle.
// - plain increment writes f+1 to the destination and updates zero.
// - or-literal ors the accumulator with an 8-bit literal into the accumulator, updating zero.
// - or-file ors the accumulator with the file register into the destination, updating zero.
// - shift-left moves bit 7 to carry, bits 6:0 up one place and a 0 into bit 0.
//
// Design decisions made here: the address map and the strobed register port.
`timescale 1ns/1ps
module branch_inc_or_shift_exec
   import exec_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic issue,
   input wire op_t op,
   input wire logic [FADDR_W-1:0] file_addr,
   input wire logic dest_sel,
   input wire logic [IMM_W-1:0] literal,
   input wire logic [LATCH_W-1:0] upper_pc_latch,
   input wire logic [BUS_ADDR_W-1:0] bus_addr,
   input wire logic [DATA_W-1:0] bus_wdata,
   input wire logic bus_wr,
   input wire logic bus_rd,
   output logic [DATA_W-1:0] bus_rdata_reg,
   output logic busy_reg,
   output logic done_reg,
   output logic [DATA_W-1:0] acc_reg,
   output logic carry_reg,
   output logic zero_reg,
   output logic [PC_W-1:0] pc_reg
);
   state_t state_reg;
   logic take;
   logic [DATA_W-1:0] f_val;
   logic [DATA_W-1:0] bus_file_val;
   logic [DATA_W-1:0] result;
   logic res_zero;
   logic to_file;
   logic to_acc;
   logic upd_zero;
   logic upd_carry;
   logic carry_next;
   logic two_cycle;
   logic [PC_W-1:0] pc_next;
   logic bank_wr;
   logic [FADDR_W-1:0] bank_waddr;
   logic [DATA_W-1:0] bank_wdata;
   logic bus_file_hit;

   ////////////////////////////////////////////////////////////////////////////
   // operation datapath

   // a new op is accepted only while not in the second cycle of another
   assign take = issue && !busy_reg;
   assign res_zero = (result == 8'h00);

   always_comb begin
      result = 8'h00;
      to_file = 1'b0;
      to_acc = 1'b0;
      upd_zero = 1'b0;
      upd_carry = 1'b0;
      carry_next = carry_reg;
      two_cycle = 1'b0;
      pc_next = pc_reg + PC_STEP;
      case (op)
         jump_absolute: begin
            pc_next = {upper_pc_latch[LATCH_HI:LATCH_LO], literal};
            two_cycle = 1'b1;
         end
         increment_skip_zero: begin
            result = f_val + 8'h01;
            to_file = dest_sel;
            to_acc = !dest_sel;
            // tested on result itself so the block never reads its own output through res_zero
            if (result == 8'h00) begin
               // the skipped instruction becomes the nop second cycle
               two_cycle = 1'b1;
               pc_next = pc_reg + PC_SKIP_STEP;
            end
         end
         increment_file: begin
            result = f_val + 8'h01;
            to_file = dest_sel;
            to_acc = !dest_sel;
            upd_zero = 1'b1;
         end
         or_literal_acc: begin
            result = acc_reg | literal[DATA_W-1:0];
            to_acc = 1'b1;
            upd_zero = 1'b1;
         end
         or_acc_file: begin
            result = acc_reg | f_val;
            to_file = dest_sel;
            to_acc = !dest_sel;
            upd_zero = 1'b1;
         end
         shift_left_file: begin
            result = {f_val[DATA_W-2:0], 1'b0};
            carry_next = f_val[DATA_W-1];
            upd_carry = 1'b1;
            to_file = dest_sel;
            to_acc = !dest_sel;
            upd_zero = 1'b1;
         end
         default: begin
            result = 8'h00;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // file registers: an executing op owns the write port, a bus write that
   // collides with it is dropped rather than stalling either side

   assign bus_file_hit = !bus_addr[BUS_ADDR_W-1];
   assign bank_wr = (take && to_file) || (bus_wr && bus_file_hit);
   assign bank_waddr = (take && to_file) ? file_addr : bus_addr[FADDR_W-1:0];
   assign bank_wdata = (take && to_file) ? result : bus_wdata;

   file_bank file_bank_inst (
      .clk(clk),
      .reset_n(reset_n),
      .wr_en(bank_wr),
      .wr_addr(bank_waddr),
      .wr_data(bank_wdata),
      .a_addr(file_addr),
      .a_data(f_val),
      .b_addr(bus_addr[FADDR_W-1:0]),
      .b_data(bus_file_val)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sequencing

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg <= st_idle;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         case (state_reg)
            st_idle: begin
               done_reg <= take && !two_cycle;
               busy_reg <= take && two_cycle;
               if (take && two_cycle) begin
                  state_reg <= st_second;
               end
            end
            st_second: begin
               state_reg <= st_idle;
               busy_reg <= 1'b0;
               done_reg <= 1'b1;
            end
            default: begin
               state_reg <= st_idle;
               busy_reg <= 1'b0;
               done_reg <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pc_reg <= PC_RESET;
      end else if (take) begin
         pc_reg <= pc_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // accumulator and flags

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         acc_reg <= ACC_RESET;
      end else if (take && to_acc) begin
         acc_reg <= result;
      end else if (bus_wr && bus_addr == ACC_OFFSET) begin
         acc_reg <= bus_wdata;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         zero_reg <= 1'b0;
         carry_reg <= 1'b0;
      end else if (take) begin
         if (upd_zero) begin
            zero_reg <= res_zero;
         end
         if (upd_carry) begin
            carry_reg <= carry_next;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register port read

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         bus_rdata_reg <= 8'h00;
      end else if (bus_rd) begin
         if (bus_file_hit) begin
            bus_rdata_reg <= bus_file_val;
         end else if (bus_addr == ACC_OFFSET) begin
            bus_rdata_reg <= acc_reg;
         end else if (bus_addr == STATUS_OFFSET) begin
            bus_rdata_reg <= 8'h00;
            bus_rdata_reg[STATUS_Z_BIT] <= zero_reg;
            bus_rdata_reg[STATUS_C_BIT] <= carry_reg;
         end else if (bus_addr == PC_LO_OFFSET) begin
            bus_rdata_reg <= pc_reg[DATA_W-1:0];
         end else if (bus_addr == PC_HI_OFFSET) begin
            bus_rdata_reg <= {1'b0, pc_reg[PC_W-1:DATA_W]};
         end else begin
            bus_rdata_reg <= 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence second_cycle_s;
      busy_reg ##1 (!busy_reg && done_reg);
   endsequence

   jump_pc_load_a: assert property (
      take && op == jump_absolute |=> pc_reg[IMM_W-1:0] == $past(literal))
      else $error("jump did not load low pc bits");
   jump_upper_bits_a: assert property (
      take && op == jump_absolute
      |=> pc_reg[PC_W-1:IMM_W] == $past(upper_pc_latch[LATCH_HI:LATCH_LO]))
      else $error("jump did not load upper pc bits");
   jump_two_cycle_a: assert property (
      take && op == jump_absolute
      |=> second_cycle_s and ($stable(zero_reg) && $stable(carry_reg)) [*2])
      else $error("jump timing or flags wrong");
   dest_select_a: assert property (
      take && op == or_acc_file && dest_sel |=> $stable(acc_reg))
      else $error("file destination disturbed the accumulator");
   skip_on_zero_a: assert property (
      take && op == increment_skip_zero && f_val == 8'hff
      |=> second_cycle_s and (pc_reg == $past(pc_reg) + PC_SKIP_STEP))
      else $error("zero result did not skip");
   skip_no_zero_a: assert property (
      take && op == increment_skip_zero && f_val != 8'hff
      |=> done_reg && !busy_reg && pc_reg == $past(pc_reg) + PC_STEP)
      else $error("nonzero result did not run the next op normally");
   skip_flags_a: assert property (
      take && op == increment_skip_zero
      |=> zero_reg == $past(zero_reg) && carry_reg == $past(carry_reg))
      else $error("increment-skip changed a flag");
   increment_zero_a: assert property (
      take && op == increment_file |=> zero_reg == ($past(f_val) == 8'hff))
      else $error("increment zero flag wrong");
   or_literal_a: assert property (
      take && op == or_literal_acc
      |=> acc_reg == ($past(acc_reg) | $past(literal[DATA_W-1:0])) && done_reg)
      else $error("or-literal result wrong");
   or_file_acc_a: assert property (
      take && op == or_acc_file && !dest_sel
      |=> acc_reg == ($past(acc_reg) | $past(f_val)))
      else $error("or-file result wrong");
   shift_carry_a: assert property (
      take && op == shift_left_file && !dest_sel
      |=> carry_reg == $past(f_val[7]) && acc_reg == {$past(f_val[6:0]), 1'b0})
      else $error("shift left result or carry wrong");
   zero_flag_a: assert property (
      take && op == or_literal_acc |=> zero_reg == (acc_reg == 8'h00))
      else $error("zero flag does not match result");
endmodule

// ---- core/exec_pkg.sv ----
// constants and types shared by the instruction execution block
// assumes one 10 MHz clock and a synchronous active-low reset
package exec_pkg;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;
   localparam int PC_W = 15;
   localparam int IMM_W = 11;
   localparam int LATCH_W = 7;
   localparam int BUS_ADDR_W = 8;
   localparam int FILE_DEPTH = 128;
   // upper pc bits come from latch bits 6:3
   localparam int LATCH_HI = 6;
   localparam int LATCH_LO = 3;
   // register port map: 0x00..0x7f reach the file registers
   localparam logic [BUS_ADDR_W-1:0] ACC_OFFSET = 8'h80;
   localparam logic [BUS_ADDR_W-1:0] STATUS_OFFSET = 8'h81;
   localparam logic [BUS_ADDR_W-1:0] PC_LO_OFFSET = 8'h82;
   localparam logic [BUS_ADDR_W-1:0] PC_HI_OFFSET = 8'h83;
   localparam int STATUS_Z_BIT = 2;
   localparam int STATUS_C_BIT = 0;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic [PC_W-1:0] PC_RESET = 15'h0000;
   localparam logic [DATA_W-1:0] FILE_RESET = 8'h00;
   localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
   localparam logic [PC_W-1:0] PC_SKIP_STEP = 15'h0002;

   typedef enum logic [2:0] {
      jump_absolute,
      increment_skip_zero,
      increment_file,
      or_literal_acc,
      or_acc_file,
      shift_left_file,
      no_operation
   } op_t;

   typedef enum logic {
      st_idle,
      st_second
   } state_t;
endpackage

// ---- core/file_bank.sv ----
// file register storage: flip-flops, one write port, two read ports
// assumes the owner arbitrates the single write port
`timescale 1ns/1ps
module file_bank
   import exec_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic wr_en,
   input wire logic [FADDR_W-1:0] wr_addr,
   input wire logic [DATA_W-1:0] wr_data,
   input wire logic [FADDR_W-1:0] a_addr,
   output logic [DATA_W-1:0] a_data,
   input wire logic [FADDR_W-1:0] b_addr,
   output logic [DATA_W-1:0] b_data
);
   logic [DATA_W-1:0] mem_reg [FILE_DEPTH];

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         for (int i = 0; i < FILE_DEPTH; i++) begin
            mem_reg[i] <= FILE_RESET;
         end
      end else if (wr_en) begin
         mem_reg[wr_addr] <= wr_data;
      end
   end

   assign a_data = mem_reg[a_addr];
   assign b_data = mem_reg[b_addr];
endmodule
